// ### include/sfc_pkg.sv
package sfc_pkg;

   // opcodes
   localparam logic [7:0] OP_LATCH_SET   = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_READ_ID     = 8'h9F;
   localparam logic [7:0] OP_READ_STATE  = 8'h05;
   localparam logic [7:0] OP_WRITE_STATE = 8'h01;
   localparam logic [7:0] OP_READ        = 8'h03;
   localparam logic [7:0] OP_FAST_READ   = 8'h0B;
   localparam logic [7:0] OP_SMALL_ERASE = 8'h20;
   localparam logic [7:0] OP_LARGE_ERASE = 8'hD8;
   localparam logic [7:0] OP_FULL_ERASE0 = 8'h60;
   localparam logic [7:0] OP_FULL_ERASE1 = 8'hC7;
   localparam logic [7:0] OP_PAGE_WRITE  = 8'h02;
   localparam logic [7:0] OP_SLEEP       = 8'hB9;
   localparam logic [7:0] OP_WAKE        = 8'hAB;
   localparam logic [7:0] OP_MAKER_PART  = 8'h90;
   localparam logic [7:0] OP_OTP_ENTER   = 8'hB1;
   localparam logic [7:0] OP_OTP_EXIT    = 8'hC1;
   localparam logic [7:0] OP_READ_SECURE = 8'h2B;
   localparam logic [7:0] OP_WRITE_SECURE = 8'h2F;

   // status byte layout
   localparam int BIT_BUSY  = 0;
   localparam int BIT_LATCH = 1;
   localparam int BIT_LEVEL = 2;
   localparam int BIT_LOCK  = 7;
   localparam logic [7:0] STATE_RESET = 8'h00;

   // frame lengths in bytes
   localparam logic [7:0] LEN_PLAIN = 8'h01;
   localparam logic [7:0] LEN_STATE = 8'h02;
   localparam logic [7:0] LEN_ERASE = 8'h04;
   localparam logic [7:0] LEN_PAGE  = 8'h05;

   // timing
   localparam int CLK_MHZ               = 125;
   localparam int STATE_WRITE_TIME_US   = 10;
   localparam int STATE_WRITE_TIME_CYC  = STATE_WRITE_TIME_US * CLK_MHZ;

   typedef enum logic [1:0] {SFC_IDLE, SFC_STATE_WR, SFC_ARRAY_OP} sfc_phase_t;

   function automatic logic sfc_valid_op(input logic [7:0] op);
      case (op)
         OP_LATCH_SET, OP_LATCH_CLEAR, OP_READ_ID, OP_READ_STATE, OP_WRITE_STATE,
         OP_READ, OP_FAST_READ, OP_SMALL_ERASE, OP_LARGE_ERASE, OP_FULL_ERASE0,
         OP_FULL_ERASE1, OP_PAGE_WRITE, OP_SLEEP, OP_WAKE, OP_MAKER_PART,
         OP_OTP_ENTER, OP_OTP_EXIT, OP_READ_SECURE, OP_WRITE_SECURE: sfc_valid_op = 1'b1;
         default: sfc_valid_op = 1'b0;
      endcase
   endfunction

endpackage

// ### rtl/sfc_sync.sv
`timescale 1ns/1ns
module sfc_sync #(
   parameter int          W     = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         en_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q2_out,
   output logic      [W-1:0] q3_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sfc_sync_t;

   sfc_sync_t r_q;
   sfc_sync_t r_d;

   always_comb begin
      r_d = r_q;
      if (en_in) begin
         r_d.s1 = d_in;
         r_d.s2 = r_q.s1;
         r_d.s3 = r_q.s2;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r_q <= {INIT, INIT, INIT};
      end else begin
         r_q <= r_d;
      end
   end

   assign q2_out = r_q.s2;
   assign q3_out = r_q.s3;
endmodule

// ### rtl/sfc_link.sv
`timescale 1ns/1ns
module sfc_link #(
   parameter logic [7:0] ID_MAKER  = 8'hA5,
   parameter logic [7:0] ID_TYPE   = 8'h5A,
   parameter logic [7:0] ID_DEVICE = 8'h3C
) (
   input  wire logic        link_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        select_n_in,
   input  wire logic        si_in,
   input  wire logic [7:0]  state_in,
   output logic      [7:0]  opcode_out,
   output logic      [7:0]  data_out,
   output logic      [23:0] addr_out,
   output logic      [7:0]  nbytes_out,
   output logic      [2:0]  phase_out,
   output logic             ignore_out,
   output logic             so_out,
   output logic             so_oe_out
);
   typedef struct packed {
      logic [2:0]  phase;
      logic [7:0]  nbytes;
      logic [7:0]  sh;
      logic [7:0]  opcode;
      logic [7:0]  data;
      logic [23:0] addr;
      logic        ignore;
      logic [7:0]  tx;
      logic [1:0]  idsel;
      logic [7:0]  snap;
   } sfc_link_t;

   sfc_link_t   l_q;
   sfc_link_t   l_d;
   logic        in_frame_q;
   logic        lrst;
   logic [7:0]  st_sync;
   logic [7:0]  st_agree;

   assign lrst = select_n_in | ~rst_n_in;

   sfc_sync #(.W(8), .INIT(sfc_pkg::STATE_RESET)) u_state_sync (
      .clk_in   (link_clk_in),
      .rst_n_in (rst_n_in),
      .en_in    (1'b1),
      .d_in     (state_in),
      .q2_out   (st_agree),
      .q3_out   (st_sync)
   );

   // marks the first rising edge of each frame
   always_ff @(posedge link_clk_in or posedge lrst) begin
      if (lrst) begin
         in_frame_q <= 1'b0;
      end else begin
         in_frame_q <= 1'b1;
      end
   end

   always_comb begin
      logic [7:0] sh_new;
      logic [7:0] op;
      sh_new = {l_q.sh[6:0], si_in};
      op     = l_q.opcode;
      l_d    = l_q;
      // status word taken only once two sync stages agree, so no torn byte
      l_d.snap = (st_agree == st_sync) ? st_sync : l_q.snap;
      if (!in_frame_q) begin
         l_d.phase  = 3'h0;
         l_d.nbytes = 8'h00;
         l_d.ignore = 1'b0;
         l_d.idsel  = 2'h0;
         sh_new     = {7'h00, si_in};
      end
      l_d.sh    = sh_new;
      l_d.phase = l_d.phase + 3'h1;
      if (l_d.phase == 3'h0) begin
         if (l_d.nbytes == 8'h00) begin
            op          = sh_new;
            l_d.opcode  = sh_new;
            l_d.ignore  = !sfc_pkg::sfc_valid_op(sh_new) ||
                          (st_sync[sfc_pkg::BIT_BUSY] &&
                           (sh_new == sfc_pkg::OP_READ_ID || sh_new == sfc_pkg::OP_READ ||
                            sh_new == sfc_pkg::OP_FAST_READ));
         end
         if (l_d.nbytes == 8'h01) begin
            l_d.data = sh_new;
         end
         if (l_d.nbytes >= 8'h01 && l_d.nbytes <= 8'h03) begin
            l_d.addr = {l_q.addr[15:0], sh_new};
         end
         if (l_d.nbytes != 8'hFF) begin
            l_d.nbytes = l_d.nbytes + 8'h01;
         end
         if (op == sfc_pkg::OP_READ_STATE) begin
            l_d.tx = l_d.snap;
         end else if (op == sfc_pkg::OP_READ_ID) begin
            case (l_d.idsel)
               2'h0:    l_d.tx = ID_MAKER;
               2'h1:    l_d.tx = ID_TYPE;
               default: l_d.tx = ID_DEVICE;
            endcase
            l_d.idsel = (l_d.idsel == 2'h2) ? 2'h0 : l_d.idsel + 2'h1;
         end else begin
            l_d.tx = 8'h00;
         end
      end
   end

   always_ff @(posedge link_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // output shifted on the falling edge, released as soon as select rises
   always_ff @(negedge link_clk_in or posedge lrst) begin
      if (lrst) begin
         so_out    <= 1'b0;
         so_oe_out <= 1'b0;
      end else if (in_frame_q && !l_q.ignore && l_q.nbytes != 8'h00 &&
                   (l_q.opcode == sfc_pkg::OP_READ_STATE ||
                    l_q.opcode == sfc_pkg::OP_READ_ID)) begin
         so_out    <= l_q.tx[~l_q.phase];
         so_oe_out <= 1'b1;
      end else begin
         so_out    <= 1'b0;
         so_oe_out <= 1'b0;
      end
   end

   assign opcode_out = l_q.opcode;
   assign data_out   = l_q.data;
   assign addr_out   = l_q.addr;
   assign nbytes_out = l_q.nbytes;
   assign phase_out  = l_q.phase;
   assign ignore_out = l_q.ignore;
endmodule

// ### rtl/sfc_top.sv
`timescale 1ns/1ns
module sfc_top #(
   parameter logic [7:0]  ID_MAKER        = 8'hA5, // arbitrary value
   parameter logic [7:0]  ID_TYPE         = 8'h5A, // arbitrary value
   parameter logic [7:0]  ID_DEVICE       = 8'h3C, // arbitrary value
   parameter logic [31:0] PAGE_WRITE_CYC  = 32'd200000,
   parameter logic [31:0] SMALL_ERASE_CYC = 32'd400000,
   parameter logic [31:0] LARGE_ERASE_CYC = 32'd800000,
   parameter logic [31:0] FULL_ERASE_CYC  = 32'd1600000
) (
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       link_clk_in,
   input  wire logic       select_n_in,
   input  wire logic       si_in,
   input  wire logic       write_guard_n_in,
   output logic            so_out,
   output logic            so_oe_out,
   output logic [7:0]      state_out,
   output logic            busy_out
);
   typedef struct packed {
      logic                   cs_n;
      logic                   guard_n;
      logic                   latch;
      logic                   busy;
      logic [3:0]             level;
      logic                   lock;
      sfc_pkg::sfc_phase_t    phase;
      logic [31:0]            timer;
      logic [7:0]             state;
   } sfc_core_t;

   sfc_core_t   c_q;
   sfc_core_t   c_d;
   logic [1:0]  pin_s2;
   logic [1:0]  pin_s3;
   logic [7:0]  lk_opcode;
   logic [7:0]  lk_data;
   logic [23:0] lk_addr;
   logic [7:0]  lk_nbytes;
   logic [2:0]  lk_phase;
   logic        lk_ignore;

   sfc_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
      .clk_in   (core_clk_in),
      .rst_n_in (rst_n_in),
      .en_in    (ce_in),
      .d_in     ({select_n_in, write_guard_n_in}),
      .q2_out   (pin_s2),
      .q3_out   (pin_s3)
   );

   sfc_link #(.ID_MAKER(ID_MAKER), .ID_TYPE(ID_TYPE), .ID_DEVICE(ID_DEVICE)) u_link (
      .link_clk_in (link_clk_in),
      .rst_n_in    (rst_n_in),
      .select_n_in (select_n_in),
      .si_in       (si_in),
      .state_in    (c_q.state),
      .opcode_out  (lk_opcode),
      .data_out    (lk_data),
      .addr_out    (lk_addr),
      .nbytes_out  (lk_nbytes),
      .phase_out   (lk_phase),
      .ignore_out  (lk_ignore),
      .so_out      (so_out),
      .so_oe_out   (so_oe_out)
   );

   // top blocks of the array guarded by a protect level
   function automatic logic guarded(input logic [3:0] lvl, input logic [23:0] a);
      logic [8:0] span;
      span = 9'h001 << (lvl - 4'h1);
      if (lvl == 4'h0) begin
         guarded = 1'b0;
      end else if (lvl >= 4'h9) begin
         guarded = 1'b1;
      end else begin
         guarded = ({1'b0, a[23:16]} >= (9'h100 - span));
      end
   endfunction

   always_comb begin
      logic cs_agree;
      logic gd_agree;
      logic frame_end;
      logic boundary;
      logic may_write;
      cs_agree  = (pin_s2[1] == pin_s3[1]) ? pin_s3[1] : c_q.cs_n;
      gd_agree  = (pin_s2[0] == pin_s3[0]) ? pin_s3[0] : c_q.guard_n;
      c_d       = c_q;
      c_d.cs_n    = cs_agree;
      c_d.guard_n = gd_agree;
      // link record is static once select is high: the link clock has stopped
      frame_end = cs_agree && !c_q.cs_n && !lk_ignore && lk_nbytes != 8'h00;
      boundary  = (lk_phase == 3'h0);
      may_write = frame_end && boundary && !c_q.busy;

      // self-timed operation countdown
      case (c_q.phase)
         sfc_pkg::SFC_STATE_WR, sfc_pkg::SFC_ARRAY_OP: begin
            if (c_q.timer <= 32'd1) begin
               c_d.busy  = 1'b0;
               c_d.latch = 1'b0;
               c_d.phase = sfc_pkg::SFC_IDLE;
               c_d.timer = 32'd0;
            end else begin
               c_d.timer = c_q.timer - 32'd1;
            end
         end
         default: begin
            c_d.busy  = 1'b0;
            c_d.timer = 32'd0;
         end
      endcase

      if (may_write) begin
         case (lk_opcode)
            sfc_pkg::OP_LATCH_SET: begin
               if (lk_nbytes == sfc_pkg::LEN_PLAIN) begin
                  c_d.latch = 1'b1;
               end
            end
            sfc_pkg::OP_LATCH_CLEAR: begin
               if (lk_nbytes == sfc_pkg::LEN_PLAIN) begin
                  c_d.latch = 1'b0;
               end
            end
            sfc_pkg::OP_WRITE_STATE: begin
               if (lk_nbytes == sfc_pkg::LEN_STATE && c_q.latch &&
                   !(c_q.lock && !gd_agree)) begin
                  c_d.level = lk_data[sfc_pkg::BIT_LEVEL +: 4];
                  c_d.lock  = lk_data[sfc_pkg::BIT_LOCK];
                  c_d.busy  = 1'b1;
                  c_d.phase = sfc_pkg::SFC_STATE_WR;
                  c_d.timer = 32'(sfc_pkg::STATE_WRITE_TIME_CYC);
               end
            end
            sfc_pkg::OP_PAGE_WRITE: begin
               if (lk_nbytes >= sfc_pkg::LEN_PAGE && c_q.latch &&
                   !guarded(c_q.level, lk_addr)) begin
                  c_d.busy  = 1'b1;
                  c_d.phase = sfc_pkg::SFC_ARRAY_OP;
                  c_d.timer = PAGE_WRITE_CYC;
               end
            end
            sfc_pkg::OP_SMALL_ERASE, sfc_pkg::OP_LARGE_ERASE: begin
               if (lk_nbytes == sfc_pkg::LEN_ERASE && c_q.latch &&
                   !guarded(c_q.level, lk_addr)) begin
                  c_d.busy  = 1'b1;
                  c_d.phase = sfc_pkg::SFC_ARRAY_OP;
                  c_d.timer = (lk_opcode == sfc_pkg::OP_SMALL_ERASE) ?
                              SMALL_ERASE_CYC : LARGE_ERASE_CYC;
               end
            end
            sfc_pkg::OP_FULL_ERASE0, sfc_pkg::OP_FULL_ERASE1: begin
               if (lk_nbytes == sfc_pkg::LEN_PLAIN && c_q.latch && c_q.level == 4'h0) begin
                  c_d.busy  = 1'b1;
                  c_d.phase = sfc_pkg::SFC_ARRAY_OP;
                  c_d.timer = FULL_ERASE_CYC;
               end
            end
            default: begin
               c_d.timer = c_d.timer;
            end
         endcase
      end

      c_d.state = {c_d.lock, 1'b0, c_d.level, c_d.latch, c_d.busy};
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c_q <= '{cs_n: 1'b1, guard_n: 1'b1, latch: 1'b0, busy: 1'b0, level: 4'h0,
                  lock: 1'b0, phase: sfc_pkg::SFC_IDLE, timer: 32'd0,
                  state: sfc_pkg::STATE_RESET};
      end else if (ce_in) begin
         c_q <= c_d;
      end
   end

   assign state_out = c_q.state;
   assign busy_out  = c_q.busy;
endmodule

// ### tb/sfc_top_sva.sv
`timescale 1ns/1ns
module sfc_top_sva (
   input wire logic       core_clk_in,
   input wire logic       rst_n_in,
   input wire logic       link_clk_in,
   input wire logic       select_n_in,
   input wire logic       si_in,
   input wire logic       so_out,
   input wire logic       so_oe_out,
   input wire logic [7:0] state_out,
   input wire logic       busy_out
);
   logic [7:0] cnt_q = 8'h00;
   logic [7:0] op_q = 8'h00;
   // rise counter and opcode capture for the current frame
   always_ff @(posedge link_clk_in or posedge select_n_in) begin
      if (select_n_in) begin
         cnt_q <= 8'h00;
         op_q  <= 8'h00;
      end else if (cnt_q < 8'h08) begin
         cnt_q <= cnt_q + 8'h01;
         op_q  <= {op_q[6:0], si_in};
      end else if (cnt_q != 8'hFF) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   property p_busy_mirror;
      @(posedge core_clk_in) disable iff (!rst_n_in) busy_out == state_out[0];
   endproperty
   a_busy_mirror: assert property (p_busy_mirror)
      else $error("busy flag differs from state bit");
   property p_bit6_zero;
      @(posedge core_clk_in) disable iff (!rst_n_in) state_out[6] == 1'b0;
   endproperty
   a_bit6_zero: assert property (p_bit6_zero)
      else $error("reserved state bit set");
   property p_oe_sel;
      @(posedge core_clk_in) disable iff (!rst_n_in) select_n_in |-> !so_oe_out;
   endproperty
   a_oe_sel: assert property (p_oe_sel)
      else $error("output driven while deselected");
   property p_level_stable;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         $changed({state_out[7], state_out[5:2]}) |-> busy_out;
   endproperty
   a_level_stable: assert property (p_level_stable)
      else $error("protect bits changed outside a state write");
   property p_busy_start;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         $rose(busy_out) |-> $past(select_n_in, 2) && $past(select_n_in, 3);
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("busy rose inside a frame");
   property p_latch_clear;
      @(posedge core_clk_in) disable iff (!rst_n_in) $fell(busy_out) |-> ##[0:2] !state_out[1];
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("latch kept after operation end");
   property p_busy_min;
      @(posedge core_clk_in) disable iff (!rst_n_in) $rose(busy_out) |-> busy_out[*8];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("busy too short");
   property p_latch_rise;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         $rose(state_out[1]) |-> $past(select_n_in, 2) && !busy_out;
   endproperty
   a_latch_rise: assert property (p_latch_rise)
      else $error("latch set inside a frame or while busy");
   property p_oe_first;
      @(posedge link_clk_in) disable iff (!rst_n_in) $rose(so_oe_out) |-> cnt_q == 8'h08;
   endproperty
   a_oe_first: assert property (p_oe_first)
      else $error("output began at wrong bit");
   property p_invalid_quiet;
      @(posedge link_clk_in) disable iff (!rst_n_in)
         (!select_n_in && cnt_q >= 8'h08 && op_q != sfc_pkg::OP_READ_STATE
          && op_q != sfc_pkg::OP_READ_ID) |-> !so_oe_out;
   endproperty
   a_invalid_quiet: assert property (p_invalid_quiet)
      else $error("output driven for non-reading opcode");
   c_busy: cover property (@(posedge core_clk_in) $rose(busy_out));
   c_latch: cover property (@(posedge core_clk_in) $rose(state_out[1]));
   c_oe: cover property (@(posedge link_clk_in) $rose(so_oe_out));
endmodule
bind sfc_top sfc_top_sva sfc_top_sva_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .link_clk_in(link_clk_in), .select_n_in(select_n_in), .si_in(si_in), .so_out(so_out),
   .so_oe_out(so_oe_out), .state_out(state_out), .busy_out(busy_out));

// ### tb/sfc_host_model.sv
`timescale 1ns/1ns
module sfc_host_model (
   output logic      link_clk_out,
   output logic      select_n_out,
   output logic      si_out,
   input  wire logic so_in,
   input  wire logic so_oe_in
);
   initial begin
      link_clk_out = 1'b0;
      select_n_out = 1'b1;
      si_out       = 1'b0;
   end
   // one frame, tx msb first; rx keeps the last 32 bits seen, x where not driven
   task automatic frame(input logic m3, input logic [39:0] tx, input int nbits,
                        output logic [31:0] rx);
      rx = 'x;
      link_clk_out = m3;
      #24;
      select_n_out = 1'b0;
      #24;
      for (int i = 0; i < nbits; i++) begin
         link_clk_out = 1'b0;
         si_out = tx[39-i];
         #24;
         link_clk_out = 1'b1;
         rx = {rx[30:0], so_oe_in ? so_in : 1'bx};
         #24;
      end
      link_clk_out = m3;
      #24;
      select_n_out = 1'b1;
      si_out = ~si_out;
      #80;
   endtask
endmodule

// ### tb/sfc_top_tb.sv
`timescale 1ns/1ns
module sfc_top_tb;
   logic        clk;
   logic        rst_n;
   logic        ce;
   logic        guard_n;
   logic        link_clk;
   logic        sel_n;
   logic        si;
   logic        so;
   logic        so_oe;
   logic        busy;
   logic [7:0]  state;
   logic [31:0] rx;
   logic [7:0]  ops [4] = '{sfc_pkg::OP_FULL_ERASE0, sfc_pkg::OP_SMALL_ERASE,
                            sfc_pkg::OP_LARGE_ERASE, sfc_pkg::OP_PAGE_WRITE};
   int          lens [4] = '{8, 32, 32, 40};
   int          fails;
   int          checks_done;
   localparam logic [31:0] ID_EXP = 32'h00B44BE1; // arbitrary identity bytes
   always #4 clk = ~clk;
   sfc_top #(.ID_MAKER(ID_EXP[23:16]), .ID_TYPE(ID_EXP[15:8]), .ID_DEVICE(ID_EXP[7:0]),
      .PAGE_WRITE_CYC(32'h190), .SMALL_ERASE_CYC(32'h190),
      .LARGE_ERASE_CYC(32'h190), .FULL_ERASE_CYC(32'h190)) sfc_top_inst (
      .core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .link_clk_in(link_clk),
      .select_n_in(sel_n), .si_in(si), .write_guard_n_in(guard_n), .so_out(so),
      .so_oe_out(so_oe), .state_out(state), .busy_out(busy));
   sfc_host_model sfc_host_model_inst (.link_clk_out(link_clk), .select_n_out(sel_n),
      .si_out(si), .so_in(so), .so_oe_in(so_oe));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic m3, input logic [39:0] tx, input int n);
      sfc_host_model_inst.frame(m3, tx, n, rx);
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 3000) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 3000) begin
         fails++;
         $display("FAIL %0t busy never cleared", $time);
      end
   endtask
   task automatic print_verdict;
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #400000;
      fails++;
      print_verdict();
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      guard_n = 1'b1;
      fails = 0;
      checks_done = 0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check({24'h0, state}, 32'h0);
      for (int m = 0; m < 2; m++) begin
         send(m[0], {sfc_pkg::OP_READ_ID, 32'h0}, 32);
         check({8'h00, rx[23:0]}, ID_EXP);
         send(m[0], {sfc_pkg::OP_LATCH_SET, 32'h0}, 8);
         check({24'h0, state}, 32'h02);
         send(m[0], {sfc_pkg::OP_READ_STATE, 32'h0}, 24);
         check({16'h0, rx[15:0]}, 32'h0202);
         send(m[0], {sfc_pkg::OP_LATCH_CLEAR, 32'h0}, 8);
         check({24'h0, state}, 32'h0);
      end
      send(0, {8'hFF, 32'h0}, 16);
      check(rx, 'x);
      send(0, {sfc_pkg::OP_LATCH_SET, 32'h0}, 7);
      check({24'h0, state}, 32'h0);
      send(0, {sfc_pkg::OP_WRITE_STATE, 8'hFF, 24'h0}, 16);
      check({24'h0, state}, 32'h0);
      send(0, {sfc_pkg::OP_LATCH_SET, 32'h0}, 8);
      send(0, {sfc_pkg::OP_WRITE_STATE, 8'hFF, 24'h0}, 16);
      check({24'h0, state}, 32'hBF);
      send(1, {sfc_pkg::OP_READ_STATE, 32'h0}, 16);
      check({24'h0, rx[7:0]}, 32'hBF);
      wait_idle();
      check({24'h0, state}, 32'hBC);
      send(0, {sfc_pkg::OP_LATCH_SET, 32'h0}, 8);
      send(0, {sfc_pkg::OP_FULL_ERASE1, 32'h0}, 8);
      check({24'h0, state}, 32'hBE);
      send(0, {sfc_pkg::OP_SMALL_ERASE, 24'hFF0000, 8'h00}, 32);
      check({24'h0, state}, 32'hBE);
      guard_n = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      send(0, {sfc_pkg::OP_WRITE_STATE, 32'h0}, 16);
      check({24'h0, state}, 32'hBE);
      guard_n = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      send(0, {sfc_pkg::OP_WRITE_STATE, 32'h0}, 16);
      check({24'h0, state}, 32'h03);
      wait_idle();
      check({24'h0, state}, 32'h0);
      for (int j = 0; j < 4; j++) begin
         send(0, {sfc_pkg::OP_LATCH_SET, 32'h0}, 8);
         send(0, {ops[j], 32'h000000A5}, lens[j]);
         check({24'h0, state}, 32'h03);
         if (j == 0) begin
            ce = 1'b0;
            repeat (500) @(posedge clk);
            #1;
            check({24'h0, state}, 32'h03);
            ce = 1'b1;
         end
         send(0, {sfc_pkg::OP_READ_ID, 32'h0}, 32);
         check(rx, 'x);
         wait_idle();
         check({24'h0, state}, 32'h0);
      end
      print_verdict();
   end
endmodule
